// ===== dv/host_port_model.sv
// Purpose: host processor on the parallel microport
// Assumes: strobes held until ack is sampled low
// Notes:   released lines show the inverse of the last value
module host_port_model
  import switch_mode_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   dtaN,
  input  wire switch_mode_pkg::word_t rdData,
  output logic                  [7:0] addr,
  output logic                        csN,
  output logic                        dsN,
  output logic                        rdWrN,
  output switch_mode_pkg::word_t      wrData
);
  int timeouts = 0;
  initial begin
    csN = 1'b1;
    dsN = 1'b1;
    rdWrN = 1'b1;
    addr = 8'h00;
    wrData = 16'h0000;
  end
  // one 16-bit word per access, write data masked to bits 9:0; strobe high one edge between accesses
  task automatic access(input logic rd, input logic [7:0] a, input word_t d, output word_t q);
    int n;
    @(posedge core_clk);
    #1;
    addr = a;
    wrData = rd ? 16'h0000 : (d & 16'h03FF);
    rdWrN = rd;
    csN = 1'b0;
    dsN = 1'b0;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (dtaN !== 1'b0 && n < 50);
    q = rdData;
    if (n >= 50) timeouts++;
    #1;
    csN = 1'b1;
    dsN = 1'b1;
    addr = ~a;
    wrData = ~wrData;
  endtask : access
endmodule : host_port_model

// ===== dv/switch_mode_monitor.sv
// Purpose: port checker for switch_mode_ctrl
// Assumes: one clock, synchronous active-low reset
// Notes:   bound at the foot of this file
module switch_mode_monitor
  import switch_mode_pkg::*;
#(
  parameter int STREAMS = 16,
  parameter int CHAN_W  = 7,
  parameter int STA_W   = 4
) (
  input wire logic                   core_clk,
  input wire logic                   rst_b,
  input wire logic                   csN,
  input wire logic                   dsN,
  input wire logic                   dtaN,
  input wire logic                   outputDrivePin,
  input wire logic [STA_W+CHAN_W-1:0] memAddr,
  input wire logic                   cmWrEn,
  input wire switch_mode_pkg::word_t cmWrData,
  input wire logic                   frameEvalStart,
  input wire logic     [STREAMS-1:0] chanOe,
  input wire logic     [STREAMS-1:0] chanLoopback,
  input wire logic     [STREAMS-1:0] streamOutEn,
  input wire logic     [STREAMS-1:0] loopbackEn,
  input wire switch_mode_pkg::rate_t rateSelect,
  input wire logic                   rateValid
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence taken_s;
    !csN && !dsN && $past(csN || dsN);
  endsequence
  sequence sweep_s;
    cmWrEn ##1 cmWrEn;
  endsequence
  ack_delay_a: assert property (taken_s |-> dtaN ##1 dtaN ##[1:2] !dtaN)
    else $error("ack not on time");
  ack_release_a: assert property (!dtaN && dsN |=> dtaN)
    else $error("ack held after strobe");
  oe_gate_a: assert property ((streamOutEn & ~chanOe) == '0)
    else $error("driver on with channel disabled");
  drive_pin_a: assert property (outputDrivePin |-> streamOutEn == chanOe)
    else $error("drive pin ignored");
  loopback_a: assert property (loopbackEn == chanLoopback)
    else $error("loopback mismatch");
  rate_valid_a: assert property (rateValid == (rateSelect != 2'b11))
    else $error("rate valid wrong");
  sweep_data_a: assert property (sweep_s |-> cmWrData[10:0] == 11'h000 && $stable(cmWrData))
    else $error("block data wrong");
  sweep_addr_a: assert property (sweep_s |-> memAddr == (STA_W+CHAN_W)'($past(memAddr) + 1'b1))
    else $error("sweep address skipped");
  eval_pulse_a: assert property (frameEvalStart |=> !frameEvalStart)
    else $error("eval start not a pulse");
endmodule : switch_mode_monitor

bind switch_mode_ctrl switch_mode_monitor #(.STREAMS(STREAMS), .CHAN_W(CHAN_W), .STA_W(STA_W)) mon_u (
  .core_clk(core_clk), .rst_b(rst_b), .csN(csN), .dsN(dsN), .dtaN(dtaN),
  .outputDrivePin(outputDrivePin), .memAddr(memAddr), .cmWrEn(cmWrEn), .cmWrData(cmWrData),
  .frameEvalStart(frameEvalStart), .chanOe(chanOe), .chanLoopback(chanLoopback),
  .streamOutEn(streamOutEn), .loopbackEn(loopbackEn), .rateSelect(rateSelect), .rateValid(rateValid));

// ===== dv/tb_switch_mode_and_block_program_ctrl.sv
// Purpose: self-checking bench for switch_mode_ctrl
// Assumes: frameStart every 64 cycles
// Notes:   one task per scenario
module tb_switch_mode_and_block_program_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  import switch_mode_pkg::*;
  logic core_clk = 0, rst_b = 0, odPin = 0, frameStart = 0, evalDone = 0, half = 0, csN, dsN, rdWrN, dtaN;
  logic cmWrEn, frameEvalStart, rateValid, evalSeen = 0;
  logic [7:0] addr;
  logic [10:0] offs = 0, memAddr, lastAddr;
  logic [15:0] chanOe = 0, chanLb = 0, streamOutEn, loopbackEn;
  word_t wrData, rdData, cmWrData, lastData, q;
  rate_t rateSelect;
  int mismatches = 0, checks_done = 0, wrCount = 0, fc = 0, n0;
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (cmWrEn === 1'b1) begin wrCount++; lastAddr = memAddr; lastData = cmWrData; end
    if (frameEvalStart === 1'b1) evalSeen = 1;
    fc = (fc + 1) % 64;
    #1 frameStart = (fc == 0);
  end
  host_port_model hostU (.core_clk(core_clk), .dtaN(dtaN), .rdData(rdData), .addr(addr), .csN(csN),
    .dsN(dsN), .rdWrN(rdWrN), .wrData(wrData));
  switch_mode_ctrl dut_u (.core_clk(core_clk), .rst_b(rst_b), .addr(addr), .csN(csN), .dsN(dsN),
    .rdWrN(rdWrN), .wrData(wrData), .rdData(rdData), .dtaN(dtaN), .outputDrivePin(odPin),
    .memAddr(memAddr), .cmWrEn(cmWrEn), .cmWrData(cmWrData), .cmRdData(16'hC3E1), .dmRdData(16'h5A0F),
    .frameStart(frameStart), .frameEvalStart(frameEvalStart), .frameEvalComplete(evalDone),
    .measuredOffset(offs), .halfPeriodFlag(half), .chanOe(chanOe), .chanLoopback(chanLb),
    .streamOutEn(streamOutEn), .loopbackEn(loopbackEn), .rateSelect(rateSelect), .rateValid(rateValid));
  task automatic check(input string name, input word_t exp, input word_t got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input word_t d);
    hostU.access(1'b0, a, d, q);
    if (hostU.timeouts > 0) stop_test();
  endtask : wr
  task automatic rd(input logic [7:0] a);
    hostU.access(1'b1, a, 16'h0000, q);
    if (hostU.timeouts > 0) stop_test();
  endtask : rd
  task automatic t_regs();
    for (int i = 0; i < 3; i++) begin rd(i[7:0]); check("reset value", 16'h0000, q); end
    for (int i = 3; i < 7; i++) wr(i[7:0], 16'(16'h0150 + i));
    for (int i = 3; i < 7; i++) begin rd(i[7:0]); check("offset reg", 16'(16'h0150 + i), q); end
    wr(8'h07, 16'h0155); rd(8'h07); check("unmapped", 16'h0000, q);
    wr(8'h02, 16'h03FF); rd(8'h02); check("result ro", 16'h0000, q);
  endtask : t_regs
  task automatic t_oe();
    chanOe = 16'hF0F1; chanLb = 16'h1234;
    wr(8'h01, 16'h0000); check("standby off", 16'h0000, streamOutEn);
    wr(8'h01, 16'h0008); check("standby on", chanOe, streamOutEn);
    wr(8'h01, 16'h0000); odPin = 1; #1 check("drive pin", chanOe, streamOutEn);
    check("loopback", chanLb, loopbackEn);
    chanLb = 16'h0000; #1 check("loopback off", 16'h0000, loopbackEn);
  endtask : t_oe
  task automatic t_rates();
    logic [6:0] m;
    for (int r = 0; r < 4; r++) begin
      m = (r == 0) ? 7'h1F : (r == 1) ? 7'h3F : 7'h7F;
      wr(8'h01, 16'(r)); check("rate", 16'(r), 16'(rateSelect)); check("rate ok", 16'(r != 3), 16'(rateValid));
      wr(8'h00, 16'h001A); wr(8'hFF, 16'h0123);
      check("mem addr", {5'h00, 4'hA, m}, 16'(lastAddr)); check("mem data", 16'h0123, lastData);
    end
  endtask : t_rates
  task automatic t_memsel();
    wr(8'h00, 16'h0010); rd(8'h85); check("conn mem", 16'hC3E1, q);
    wr(8'h00, 16'h0000); rd(8'h85); check("data mem", 16'h5A0F, q); n0 = wrCount;
    wr(8'h85, 16'h0011); check("data mem ro", 16'(n0), 16'(wrCount));
  endtask : t_memsel
  task automatic t_eval();
    wr(8'h01, 16'h0000); repeat (70) @(posedge core_clk);
    #1 evalSeen = 0; wr(8'h01, 16'h0004); check("eval start", 16'h0001, 16'(evalSeen));
    offs = 11'h5A5; half = 1; evalDone = 1; @(posedge core_clk); #1 evalDone = 0;
    rd(8'h02); check("result", 16'h8DA5, q);
    wr(8'h01, 16'h0000); rd(8'h02); check("result clear", 16'h0000, q);
  endtask : t_eval
  task automatic t_block();
    int k;
    wr(8'h00, 16'h0030); n0 = wrCount; wr(8'h01, 16'h02B0); k = 0;
    do begin rd(8'h01); k++; end while (q[4] !== 1'b0 && k < 1000);
    check("begin self clear", 16'h02A0, q); check("sweep len", 16'd2048, 16'(wrCount - n0));
    check("sweep data", 16'hA800, lastData); check("sweep end", 16'h07FF, 16'(lastAddr));
    if (q[4] !== 1'b0) stop_test();
  endtask : t_block
  task automatic t_abort(input logic [7:0] a, input word_t d);
    wr(8'h00, 16'h0030); wr(8'h01, 16'h02A0); n0 = wrCount;
    wr(8'h01, 16'h02B0); wr(a, d); repeat (2100) @(posedge core_clk);
    check("aborted", 16'h0001, 16'((wrCount - n0) < 2048));
  endtask : t_abort
  task automatic stop_test();
    mismatches += hostU.timeouts;
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  initial begin
    repeat (20) @(posedge core_clk);
    #1 rst_b = 1;
    t_regs();
    t_oe();
    t_rates();
    t_memsel();
    t_eval();
    t_block();
    t_abort(8'h01, 16'h02A0);
    t_abort(8'h00, 16'h0010);
    stop_test();
  end
endmodule : tb_switch_mode_and_block_program_ctrl

// ===== hw/output_enable_ctrl.sv
// Purpose: per-stream output driver enable gating and loopback pass-through
// Assumes: chanOe and chanLoopback are the bits of the channel now on each stream
// Notes:   combinational, one slice per stream
module output_enable_ctrl #(
  parameter int STREAMS = 16
) (
  // per-stream connection memory bits
  input  wire logic [STREAMS-1:0] chanOe,
  input  wire logic [STREAMS-1:0] chanLoopback,
  // global controls
  input  wire logic               outputDrivePin,
  input  wire logic               outputStandbyBit,
  // driver controls
  output logic      [STREAMS-1:0] streamOutEn,
  output logic      [STREAMS-1:0] loopbackEn
);

  wire globalEn = outputDrivePin | outputStandbyBit;

  genvar g;
  generate
    for (g = 0; g < STREAMS; g = g + 1) begin : g_stream
      assign streamOutEn[g] = chanOe[g] & globalEn;
      assign loopbackEn[g]  = chanLoopback[g];
    end
  endgenerate

endmodule : output_enable_ctrl

// ===== hw/switch_mode_ctrl.sv
// Purpose: microport register bank, memory address decode, block programming,
//          frame evaluation control and output driver gating
// Assumes: one access per strobe; memory read data valid the cycle after memAddr
// Notes:   frameStart pulses once per serial frame
`include "switch_mode_params.svh"

module switch_mode_ctrl
  import switch_mode_pkg::*;
#(
  parameter int STREAMS = 16,
  parameter int CHAN_W  = 7,
  parameter int STA_W   = 4
) (
  // clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    rst_b,
  // microport
  input  wire logic              [7:0] addr,
  input  wire logic                    csN,
  input  wire logic                    dsN,
  input  wire logic                    rdWrN,
  input  wire switch_mode_pkg::word_t  wrData,
  output switch_mode_pkg::word_t       rdData,
  output logic                         dtaN,
  // pins
  input  wire logic                    outputDrivePin,
  // connection and data memory
  output logic     [STA_W+CHAN_W-1:0]  memAddr,
  output logic                         cmWrEn,
  output switch_mode_pkg::word_t       cmWrData,
  input  wire switch_mode_pkg::word_t  cmRdData,
  input  wire switch_mode_pkg::word_t  dmRdData,
  // frame timing and evaluation
  input  wire logic                    frameStart,
  output logic                         frameEvalStart,
  input  wire logic                    frameEvalComplete,
  input  wire logic             [10:0] measuredOffset,
  input  wire logic                    halfPeriodFlag,
  // serial side controls
  input  wire logic      [STREAMS-1:0] chanOe,
  input  wire logic      [STREAMS-1:0] chanLoopback,
  output logic           [STREAMS-1:0] streamOutEn,
  output logic           [STREAMS-1:0] loopbackEn,
  output switch_mode_pkg::rate_t       rateSelect,
  output logic                         rateValid
);

  import switch_mode_pkg::*;

  localparam int AW = STA_W + CHAN_W;
  localparam logic [AW-1:0] SWEEP_LAST = {AW{1'b1}};

  function automatic logic regHit(input logic [7:0] a, input logic [6:0] idx);
    regHit = (a[`ADDR_SPACE_BIT] == 1'b0) && (a[6:0] == idx);
  endfunction : regHit

  // ****************************************
  // state
  // ****************************************
  word_t            ctrl_r, ctrl_nxt;
  word_t            ims_r, ims_nxt;
  word_t            far_r, far_nxt;
  word_t            ofs_r [4];
  word_t            rdData_r, rdData_nxt;
  logic             take_r, ack_r, busy_r;
  logic [7:0]       addrHold_r;
  logic             rdHold_r;
  bp_state_t        bpState_r, bpState_nxt;
  logic [AW-1:0]    sweep_r, sweep_nxt;
  logic             sfeArmed_r, sfeArmed_nxt;
  logic             evalRun_r, evalRun_nxt;
  logic             evalPulse_r, evalPulse_nxt;

  // ****************************************
  // microport decode
  // ****************************************
  wire       access     = ~csN & ~dsN;
  wire       takeNow    = access & ~busy_r;
  wire       wrNow      = takeNow & ~rdWrN;
  wire       memSpace   = addr[`ADDR_SPACE_BIT];
  wire       wrCtrl     = wrNow & regHit(addr, `CTRL_IDX);
  wire       wrIms      = wrNow & regHit(addr, `IMS_IDX);
  wire       memSel     = ctrl_r[`CR_MS_BIT];
  wire       ctrl_block_prog_bit        = ctrl_r[`CR_MBP_BIT];
  wire [STA_W-1:0] stream_subsection_bits  = ctrl_r[`CR_STA_HI:`CR_STA_LO];

  assign rateSelect = ims_r[`IMS_DR_HI:`IMS_DR_LO];
  assign rateValid  = (rateSelect != `RATE_RSVD);

  wire [6:0] chanMask = (rateSelect == `RATE_2M) ? `MASK_2M :
                        (rateSelect == `RATE_4M) ? `MASK_4M : `MASK_8M;
  wire [6:0] hostChan = addr[6:0] & chanMask;
  wire [6:0] holdChan = addrHold_r[6:0] & chanMask;

  // ****************************************
  // block programming
  // ****************************************
  wire       bpeOld     = ims_r[`IMS_BPE_BIT];
  wire       bpeNew     = wrData[`IMS_BPE_BIT];
  wire       bpStart    = wrIms & ~bpeOld & bpeNew & (wrCtrl ? wrData[`CR_MBP_BIT] : ctrl_block_prog_bit);
  wire       bpAbort    = (wrIms & ~bpeNew) | (wrCtrl & ~wrData[`CR_MBP_BIT]);
  wire       bpDone     = (bpState_r == BP_RUN) & (sweep_r == SWEEP_LAST);
  wire [4:0] bpValue    = ims_r[`IMS_BPD_HI:`IMS_BPD_LO];

  always_comb begin
    bpState_nxt = bpState_r;
    sweep_nxt   = sweep_r;
    case (bpState_r)
      BP_IDLE: begin
        sweep_nxt = '0;
        if (bpStart) begin
          bpState_nxt = BP_RUN;
        end
      end
      BP_RUN: begin
        sweep_nxt = sweep_r + 1'b1;
        if (bpAbort || bpDone) begin
          bpState_nxt = BP_IDLE;
        end
      end
      default: bpState_nxt = BP_IDLE;
    endcase
  end

  // memory port: sweep owns it during block programming
  wire bpWrite   = (bpState_r == BP_RUN);
  wire hostMemWr = wrNow & memSpace & memSel & ~bpWrite;
  assign memAddr  = bpWrite ? sweep_r :
                    (busy_r ? {stream_subsection_bits, holdChan} : {stream_subsection_bits, hostChan});
  assign cmWrEn   = bpWrite | hostMemWr;
  assign cmWrData = bpWrite ? {bpValue, {`CM_BPD_LO{1'b0}}} : wrData;

  // ****************************************
  // register writes
  // ****************************************
  wire sfeOld = ims_r[`IMS_SFE_BIT];
  wire sfeNew = wrIms ? wrData[`IMS_SFE_BIT] : sfeOld;
  wire sfeRise = ~sfeOld & sfeNew;
  wire sfeFall = sfeOld & ~sfeNew;

  always_comb begin
    ctrl_nxt = ctrl_r;
    ims_nxt  = ims_r;
    if (wrCtrl) begin
      ctrl_nxt = wrData;
    end
    if (wrIms) begin
      ims_nxt = wrData;
    end
    if (bpWrite && bpDone && !bpAbort) begin
      ims_nxt[`IMS_BPE_BIT] = 1'b0;
    end
  end

  // ****************************************
  // frame evaluation
  // ****************************************
  always_comb begin
    sfeArmed_nxt  = sfeArmed_r;
    evalRun_nxt   = evalRun_r;
    evalPulse_nxt = 1'b0;
    far_nxt       = far_r;
    if (!sfeOld && frameStart) begin
      sfeArmed_nxt = 1'b1;
    end
    if (sfeRise && sfeArmed_r) begin
      evalRun_nxt   = 1'b1;
      evalPulse_nxt = 1'b1;
      sfeArmed_nxt  = 1'b0;
    end else if (sfeRise) begin
      sfeArmed_nxt = 1'b0;
    end
    if (sfeFall) begin
      far_nxt = `WORD_ZERO;
      evalRun_nxt = 1'b0;
    end
    if (evalRun_r && frameEvalComplete) begin
      far_nxt[`FAR_FD_HI:0]   = measuredOffset;
      far_nxt[`FAR_HALF_BIT]  = halfPeriodFlag;
      far_nxt[`FAR_CFE_BIT]   = 1'b1;
      evalRun_nxt             = 1'b0;
    end
  end

  assign frameEvalStart = evalPulse_r;

  // ****************************************
  // read mux, one cycle after take
  // ****************************************
  wire [6:0] hIdx   = addrHold_r[6:0];
  wire       hReg   = ~addrHold_r[`ADDR_SPACE_BIT];
  wire       hOfs   = hReg & (hIdx >= `OFS0_IDX) & (hIdx <= `OFS3_IDX);
  wire [1:0] ofsSel = 2'(hIdx - `OFS0_IDX);

  always_comb begin
    rdData_nxt = rdData_r;
    if (take_r && rdHold_r) begin
      if (!hReg) begin
        rdData_nxt = memSel ? cmRdData : dmRdData;
      end else if (hIdx == `CTRL_IDX) begin
        rdData_nxt = ctrl_r;
      end else if (hIdx == `IMS_IDX) begin
        rdData_nxt = ims_r;
      end else if (hIdx == `FAR_IDX) begin
        rdData_nxt = far_r;
      end else if (hOfs) begin
        rdData_nxt = ofs_r[ofsSel];
      end else begin
        rdData_nxt = `WORD_ZERO;
      end
    end
  end

  assign rdData = rdData_r;
  assign dtaN   = ~ack_r;

  // ****************************************
  // flip-flops
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ctrl_r      <= `CR_RESET;
      ims_r       <= `IMS_RESET;
      far_r       <= `WORD_ZERO;
      bpState_r   <= BP_IDLE;
      sweep_r     <= '0;
      sfeArmed_r  <= 1'b1;
      evalRun_r   <= 1'b0;
      evalPulse_r <= 1'b0;
    end else begin
      ctrl_r      <= ctrl_nxt;
      ims_r       <= ims_nxt;
      far_r       <= far_nxt;
      bpState_r   <= bpState_nxt;
      sweep_r     <= sweep_nxt;
      sfeArmed_r  <= sfeArmed_nxt;
      evalRun_r   <= evalRun_nxt;
      evalPulse_r <= evalPulse_nxt;
    end
  end

  genvar o;
  generate
    for (o = 0; o < 4; o = o + 1) begin : g_ofs
      always_ff @(posedge core_clk) begin
        if (!rst_b) begin
          ofs_r[o] <= `WORD_ZERO;
        end else if (wrNow && regHit(addr, 7'(`OFS0_IDX + o))) begin
          ofs_r[o] <= wrData;
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      take_r     <= 1'b0;
      busy_r     <= 1'b0;
      ack_r      <= 1'b0;
      addrHold_r <= 8'h00;
      rdHold_r   <= 1'b0;
      rdData_r   <= `WORD_ZERO;
    end else begin
      take_r   <= takeNow;
      busy_r   <= access;
      ack_r    <= access & (take_r | ack_r);
      rdData_r <= rdData_nxt;
      if (takeNow) begin
        addrHold_r <= addr;
        rdHold_r   <= rdWrN;
      end
    end
  end

  // ****************************************
  // output drivers
  // ****************************************
  output_enable_ctrl #(
    .STREAMS (STREAMS)
  ) u_oe (
    .chanOe           (chanOe),
    .chanLoopback     (chanLoopback),
    .outputDrivePin   (outputDrivePin),
    .outputStandbyBit (ims_r[`IMS_OSB_BIT]),
    .streamOutEn      (streamOutEn),
    .loopbackEn       (loopbackEn)
  );

endmodule : switch_mode_ctrl

// ===== hw/switch_mode_params.svh
// Purpose: named constants for the switch mode and block program control
// Assumes: microport word registers, 16 serial output streams
// Notes:   definitions only
`ifndef SWITCH_MODE_PARAMS_SVH
`define SWITCH_MODE_PARAMS_SVH

// ****************************************
// register indices (top address line low)
// ****************************************
`define ADDR_SPACE_BIT   7
`define CTRL_IDX         7'h00
`define IMS_IDX          7'h01
`define FAR_IDX          7'h02
`define OFS0_IDX         7'h03
`define OFS3_IDX         7'h06

// ****************************************
// control register fields
// ****************************************
`define CR_STA_HI        3
`define CR_STA_LO        0
`define CR_MS_BIT        4
`define CR_MBP_BIT       5
`define CR_RESET         16'h0000

// ****************************************
// interface mode select fields
// ****************************************
`define IMS_BPD_HI       9
`define IMS_BPD_LO       5
`define IMS_BPE_BIT      4
`define IMS_OSB_BIT      3
`define IMS_SFE_BIT      2
`define IMS_DR_HI        1
`define IMS_DR_LO        0
`define IMS_RESET        16'h0000

// ****************************************
// frame alignment result fields
// ****************************************
`define FAR_FD_HI        10
`define FAR_HALF_BIT     11
`define FAR_CFE_BIT      15

// ****************************************
// connection memory word and rate codes
// ****************************************
`define CM_BPD_LO        11
`define RATE_2M          2'b00
`define RATE_4M          2'b01
`define RATE_8M          2'b10
`define RATE_RSVD        2'b11
`define MASK_2M          7'h1F
`define MASK_4M          7'h3F
`define MASK_8M          7'h7F
`define WORD_ZERO        16'h0000

`endif

// ===== hw/switch_mode_pkg.sv
// Purpose: types shared by the switch mode control files
// Assumes: nothing
// Notes:   constants live in switch_mode_params.svh
package switch_mode_pkg;

  typedef logic [15:0] word_t;
  typedef logic [1:0]  rate_t;
  typedef enum logic {BP_IDLE, BP_RUN} bp_state_t;

endpackage : switch_mode_pkg
